// [hw/port_io_defines.vh]
`ifndef PORT_IO_DEFINES_VH
`define PORT_IO_DEFINES_VH

// special function register byte addresses
`define ADDR_PORT0_PINS      8'h80
`define ADDR_PORT1_PINS      8'h90
`define ADDR_PORT2_PINS      8'ha0
`define ADDR_PORT0_DRIVE_SEL 8'ha4
`define ADDR_PORT0_ANA_SEL   8'hf1

// reset values
`define RST_PORT_LATCH       8'hff
`define RST_PORT0_DRIVE_SEL  8'h00
`define RST_PORT0_ANA_SEL    8'hff

// pin index ranges inside the 24-bit pin vectors
`define PORT0_LSB 0
`define PORT1_LSB 8
`define PORT2_LSB 16

`endif

// [hw/port_match_detect.v]
`timescale 1ns/1ns
`default_nettype none

// masked compare of one 8-bit port against its compare value
module port_match_detect (
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  input  wire [7:0] i_pins,
  input  wire [7:0] i_compare_mask,
  input  wire [7:0] i_compare_value,
  output reg        o_mismatch
);

  // registered so the event is glitch free for the wake logic
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mismatch <= 1'b0;
    end else begin
      o_mismatch <= ((i_pins & i_compare_mask) != (i_compare_value & i_compare_mask));
    end
  end

endmodule // port_match_detect

`default_nettype wire

// [hw/port_io_with_match_detect.v]
// What this block does
// - A pin not owned by a routed peripheral and not analog is driven from its port latch as general purpose I/O.
// - Each port data register can be written as a whole byte or as one addressed bit.
// - A write stores into an output latch that keeps setting the pin levels until written again.
// - A normal read of a port data register returns the synchronised pin levels, analog pins reading zero, even for peripheral pins.
// - A read flagged as read-modify-write returns the output latch instead of the pins.
// - A match event is raised while either first or second port masked pins differ from the masked compare value.
// - Match detection looks at the synchronised pin levels of the first two ports, analog pins reading zero, regardless of routing.
// - The match event gives an interrupt request only while the match interrupt enable bit is one.
// - The match event is also offered as a wake-up for the suspended internal oscillator.
`timescale 1ns/1ns
`default_nettype none
`include "port_io_defines.vh"

module port_io_with_match_detect (
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  // special function register access
  input  wire [7:0]  i_sfr_addr,
  input  wire        i_sfr_wr,
  input  wire [7:0]  i_sfr_wdata,
  input  wire        i_sfr_bit_wr,
  input  wire [2:0]  i_sfr_bit_idx,
  input  wire        i_sfr_bit_val,
  input  wire        i_sfr_rd,
  input  wire        i_sfr_rmw,
  output reg  [7:0]  o_sfr_rdata,
  // compare setup and interrupt enable
  input  wire [7:0]  i_first_port_compare_mask,
  input  wire [7:0]  i_first_port_compare_value,
  input  wire [7:0]  i_second_port_compare_mask,
  input  wire [7:0]  i_second_port_compare_value,
  input  wire        i_match_irq_enable,
  // routing from the pin crossbar
  input  wire [23:0] i_pin_periph_sel,
  input  wire [23:0] i_pin_periph_out,
  input  wire [23:0] i_pin_two_wire,
  // pins
  input  wire [23:0] i_pin_in,
  output reg  [23:0] o_pin_out,
  output reg  [23:0] o_pin_oe,
  output reg  [23:0] o_pin_pullup_en,
  // events
  output reg         o_match_event,
  output reg         o_match_irq,
  output reg         o_osc_wake
);

  reg  [7:0]  first_port_pins;
  reg  [7:0]  second_port_pins;
  reg  [7:0]  third_port_pins;
  reg  [7:0]  first_port_drive_select;
  reg  [7:0]  first_port_analog_select;
  reg  [23:0] pin_meta;
  reg  [23:0] pin_sync;
  wire [23:0] pin_level;
  wire [23:0] latch_all;
  wire [23:0] analog_all;
  wire [23:0] pushpull_all;
  wire        first_mismatch;
  wire        second_mismatch;
  reg  [23:0] next_pin_out;
  reg  [23:0] next_pin_oe;
  reg  [7:0]  next_rdata;
  integer     n;

  // replace one bit of a latch byte
  function [7:0] set_bit;
    input [7:0] value;
    input [2:0] idx;
    input       bit_val;
    reg   [7:0] tmp;
    begin
      tmp      = value;
      tmp[idx] = bit_val;
      set_bit  = tmp;
    end
  endfunction

  // next latch value for one port: byte write, then bit write
  function [7:0] latch_update;
    input [7:0] value;
    input       hit;
    begin
      latch_update = value;
      if (hit && i_sfr_wr) begin
        latch_update = i_sfr_wdata;
      end else if (hit && i_sfr_bit_wr) begin
        latch_update = set_bit(value, i_sfr_bit_idx, i_sfr_bit_val);
      end
    end
  endfunction

  // two-stage synchroniser; only the second stage is read
  // costs two cycles of pin-to-read latency, the price of a clean sample
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta <= 24'h000000;
      pin_sync <= 24'h000000;
    end else begin
      pin_meta <= i_pin_in;
      pin_sync <= pin_meta;
    end
  end

  assign analog_all   = {16'h0000, ~first_port_analog_select};
  assign pushpull_all = {16'h0000, first_port_drive_select};
  assign latch_all    = {third_port_pins, second_port_pins, first_port_pins};
  // analog pins have their digital receiver off, so they read zero
  assign pin_level    = pin_sync & ~analog_all;

  // latches and mode registers; contents persist until rewritten
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      first_port_pins          <= `RST_PORT_LATCH;
      second_port_pins         <= `RST_PORT_LATCH;
      third_port_pins          <= `RST_PORT_LATCH;
      first_port_drive_select  <= `RST_PORT0_DRIVE_SEL;
      first_port_analog_select <= `RST_PORT0_ANA_SEL;
    end else begin
      first_port_pins  <= latch_update(first_port_pins, i_sfr_addr == `ADDR_PORT0_PINS);
      second_port_pins <= latch_update(second_port_pins, i_sfr_addr == `ADDR_PORT1_PINS);
      third_port_pins  <= latch_update(third_port_pins, i_sfr_addr == `ADDR_PORT2_PINS);
      if (i_sfr_wr && i_sfr_addr == `ADDR_PORT0_DRIVE_SEL) begin
        first_port_drive_select <= i_sfr_wdata;
      end
      if (i_sfr_wr && i_sfr_addr == `ADDR_PORT0_ANA_SEL) begin
        first_port_analog_select <= i_sfr_wdata;
      end
    end
  end

  // read mux: pins for plain reads, latch for read-modify-write
  always @* begin
    next_rdata = 8'h00;
    if (i_sfr_addr == `ADDR_PORT0_PINS) begin
      next_rdata = i_sfr_rmw ? first_port_pins : pin_level[7:0];
    end else if (i_sfr_addr == `ADDR_PORT1_PINS) begin
      next_rdata = i_sfr_rmw ? second_port_pins : pin_level[15:8];
    end else if (i_sfr_addr == `ADDR_PORT2_PINS) begin
      next_rdata = i_sfr_rmw ? third_port_pins : pin_level[23:16];
    end else if (i_sfr_addr == `ADDR_PORT0_DRIVE_SEL) begin
      next_rdata = first_port_drive_select;
    end else if (i_sfr_addr == `ADDR_PORT0_ANA_SEL) begin
      next_rdata = first_port_analog_select;
    end
  end

  // pin driver decision per pin
  always @* begin
    next_pin_out = 24'h000000;
    next_pin_oe  = 24'h000000;
    for (n = 0; n < 24; n = n + 1) begin
      next_pin_out[n] = i_pin_periph_sel[n] ? i_pin_periph_out[n] : latch_all[n];
      if (analog_all[n]) begin
        next_pin_oe[n] = 1'b0;
      end else if (pushpull_all[n] && !i_pin_two_wire[n]) begin
        next_pin_oe[n] = 1'b1;
      end else begin
        // open drain: a one floats, a zero pulls low
        next_pin_oe[n] = ~next_pin_out[n];
      end
    end
  end

  // registered pin outputs and read data
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_out       <= 24'hffffff;
      o_pin_oe        <= 24'h000000;
      o_pin_pullup_en <= 24'h000000;
      o_sfr_rdata     <= 8'h00;
    end else begin
      o_pin_out       <= next_pin_out;
      o_pin_oe        <= next_pin_oe;
      o_pin_pullup_en <= ~analog_all;
      // read data stands until the next read strobe
      if (i_sfr_rd) begin
        o_sfr_rdata <= next_rdata;
      end
    end
  end

  // synchronised pins, analog-gated but not routing-gated, feed the comparators
  port_match_detect u_first_match (
    .i_sys_clk       (i_sys_clk),
    .i_nrst          (i_nrst),
    .i_pins          (pin_level[7:0]),
    .i_compare_mask  (i_first_port_compare_mask),
    .i_compare_value (i_first_port_compare_value),
    .o_mismatch      (first_mismatch)
  );

  port_match_detect u_second_match (
    .i_sys_clk       (i_sys_clk),
    .i_nrst          (i_nrst),
    .i_pins          (pin_level[15:8]),
    .i_compare_mask  (i_second_port_compare_mask),
    .i_compare_value (i_second_port_compare_value),
    .o_mismatch      (second_mismatch)
  );

  // event is a level; it lasts while the mismatch lasts
  // no edge capture: a pattern shorter than one clock period can be missed
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_match_event <= 1'b0;
      o_match_irq   <= 1'b0;
      o_osc_wake    <= 1'b0;
    end else begin
      o_match_event <= first_mismatch | second_mismatch;
      o_match_irq   <= (first_mismatch | second_mismatch) & i_match_irq_enable;
      o_osc_wake    <= first_mismatch | second_mismatch;
    end
  end

endmodule // port_io_with_match_detect

`default_nettype wire

// [verif/port_io_with_match_detect_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module port_io_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_bit_wr,
  input wire logic        i_sfr_rd,
  input wire logic        i_sfr_rmw,
  input wire logic        i_match_irq_enable,
  input wire logic        o_match_event,
  input wire logic        o_match_irq,
  input wire logic        o_osc_wake,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic [7:0]  i_second_port_compare_mask,
  input wire logic [7:0]  i_second_port_compare_value,
  input wire logic [23:0] i_pin_periph_sel,
  input wire logic [23:0] i_pin_two_wire,
  input wire logic [23:0] i_pin_in,
  input wire logic [23:0] o_pin_out,
  input wire logic [23:0] o_pin_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // second port pins and their masked difference; stability windows cover the synchroniser
  wire [7:0] second_lvl  = i_pin_in[15:8];
  wire [7:0] second_diff = (second_lvl ^ i_second_port_compare_value) & i_second_port_compare_mask;
  property p_rd_pin; i_sfr_rd && !i_sfr_rmw && i_sfr_addr == 8'h90 && $stable(second_lvl)
    && second_lvl == $past(second_lvl, 2) && second_lvl == $past(second_lvl, 3)
    |=> o_sfr_rdata == $past(second_lvl, 2); endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");
  property p_rd_latch; i_sfr_rd && i_sfr_rmw && i_sfr_addr == 8'h90 && !i_sfr_wr && !i_sfr_bit_wr
    |=> $past(i_pin_periph_sel[15:8]) != 8'h00 || o_sfr_rdata == o_pin_out[15:8]; endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("latch read wrong");
  property p_wr_out; (i_sfr_wr && i_sfr_addr == 8'h90) ##1 (!i_sfr_wr && i_pin_periph_sel[15:8] == 8'h00)
    |=> o_pin_out[15:8] == $past(i_sfr_wdata, 2); endproperty
  a_wr_out: assert property (p_wr_out) else $error("latch not on pins");
  property p_event; ($stable(second_lvl) && $stable({i_second_port_compare_mask, i_second_port_compare_value})
    && second_diff != 8'h00) [*5] |-> o_match_event; endproperty
  a_event: assert property (p_event) else $error("mismatch missed");
  property p_irq; o_match_irq == (o_match_event && $past(i_match_irq_enable)); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_wake; o_osc_wake == o_match_event; endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  property p_od; o_pin_oe[23:8] == ~o_pin_out[23:8]; endproperty
  a_od: assert property (p_od) else $error("open drain broken");
  property p_two_wire; (o_pin_oe[7:0] & o_pin_out[7:0] & $past(i_pin_two_wire[7:0])) == 8'h00; endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire pin driven high");
endmodule // port_io_sva
bind port_io_with_match_detect port_io_sva i_port_io_sva (.*);
`default_nettype wire

// [verif/board_model.sv]
`timescale 1ns/1ns
`default_nettype none
module board_model (
  input  wire logic        i_clk,
  input  wire logic [23:0] i_out,
  input  wire logic [23:0] i_oe,
  input  wire logic [23:0] i_pu,
  input  wire logic [23:0] i_drv,
  input  wire logic [23:0] i_val,
  output wire logic [23:0] o_lvl
);
  logic flt = 1'b0;
  // a bare line wanders so a stale level never reads back by luck
  always @(posedge i_clk) flt <= ~flt;
  // device drive wins over board drive, then weak pull-up
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_drv & i_val) | (~i_oe & ~i_drv & (i_pu | {24{flt}}));
endmodule // board_model
`default_nettype wire

// [verif/port_io_with_match_detect_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module port_io_with_match_detect_tb;
  logic        i_sys_clk, i_nrst, i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_val, i_sfr_rd, i_sfr_rmw, i_match_irq_enable;
  logic        o_match_event, o_match_irq, o_osc_wake;
  logic [2:0]  i_sfr_bit_idx;
  logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_first_port_compare_mask, i_first_port_compare_value;
  logic [7:0]  i_second_port_compare_mask, i_second_port_compare_value;
  logic [23:0] i_pin_periph_sel, i_pin_periph_out, i_pin_two_wire, i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup_en;
  logic [23:0] ext_drv, ext_val;
  int          miscompares = 0, num_checks = 0;
  // system clock
  always #5 i_sys_clk = ~i_sys_clk;
  port_io_with_match_detect i_port_io_with_match_detect (.*);
  board_model i_board_model (.i_clk(i_sys_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pu(o_pin_pullup_en),
    .i_drv(ext_drv), .i_val(ext_val), .o_lvl(i_pin_in));
  task automatic chk(input string what, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // op is {byte write, bit write, read, rmw}; a bit write puts d[3] into bit d[2:0]
  task automatic acc(input logic [7:0] a, d, input logic [3:0] op);
    @(posedge i_sys_clk);
    {i_sfr_addr, i_sfr_wdata, i_sfr_bit_val, i_sfr_bit_idx} <= {a, d, d[3:0]};
    {i_sfr_wr, i_sfr_bit_wr, i_sfr_rd, i_sfr_rmw} <= op;
    @(posedge i_sys_clk);
    {i_sfr_wr, i_sfr_bit_wr, i_sfr_rd} <= 3'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    acc(a, 8'h00, {3'h1, m});
    chk("read data", e, o_sfr_rdata);
  endtask
  // six cycles outlast the sync and compare stages
  task automatic mchk(input logic [2:0] e);
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk("event irq wake", {5'h00, e}, {5'h00, o_match_event, o_match_irq, o_osc_wake});
  endtask
  task automatic results;
    $display("%0d checks, %0d mismatches", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // test sequence
  initial begin
    {i_sys_clk, i_nrst, i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_val, i_sfr_rd, i_sfr_rmw, i_match_irq_enable} = 8'h00;
    {i_sfr_addr, i_sfr_wdata, i_sfr_bit_idx, i_pin_periph_sel, i_pin_periph_out, i_pin_two_wire} = 91'h0;
    {i_first_port_compare_mask, i_first_port_compare_value, i_second_port_compare_mask} = 24'h0;
    {i_second_port_compare_value, ext_drv, ext_val} = 56'h0;
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(8'h80, 1'b1, 8'hff);
    rd(8'ha4, 1'b0, 8'h00);
    rd(8'hf1, 1'b0, 8'hff);
    rd(8'h55, 1'b0, 8'h00);
    $display("reset test done");
    // board drives second port pins to 3c while the latch stays high
    {ext_drv[15:8], ext_val[15:8]} <= 16'hff3c;
    repeat (4) @(posedge i_sys_clk);
    rd(8'h90, 1'b0, 8'h3c);
    rd(8'h90, 1'b1, 8'hff);
    acc(8'h90, 8'h00, 4'h4);
    rd(8'h90, 1'b1, 8'hfe);
    acc(8'h90, 8'h5a, 4'h8);
    rd(8'h90, 1'b1, 8'h5a);
    $display("latch test done");
    acc(8'ha4, 8'h0f, 4'h8);
    acc(8'h80, 8'ha5, 4'h8);
    @(posedge i_sys_clk);
    i_pin_two_wire[0] <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk("first port enables", 8'h5e, o_pin_oe[7:0]);
    chk("first port out", 8'ha5, o_pin_out[7:0]);
    acc(8'ha4, 8'h00, 4'h8);
    acc(8'h80, 8'hff, 4'h8);
    acc(8'hf1, 8'hfe, 4'h8);
    {ext_drv[7:0], ext_val[7:0]} <= 16'hffff;
    repeat (4) @(posedge i_sys_clk);
    rd(8'h80, 1'b0, 8'hfe);
    chk("analog pin enables", 8'h00, {6'h00, o_pin_oe[0], o_pin_pullup_en[0]});
    $display("mode test done");
    // second port pins handed to a peripheral that outputs ones and releases them, so the board drives them to 0c
    @(posedge i_sys_clk);
    {i_pin_periph_sel[15:8], i_pin_periph_out[15:8], ext_val[15:8]} <= 24'hffff0c;
    {i_second_port_compare_mask, i_second_port_compare_value} <= 16'h0f0c;
    mchk(3'h0);
    ext_val[15:8] <= 8'h0d;
    mchk(3'h5);
    @(posedge i_sys_clk);
    i_match_irq_enable <= 1'b1;
    mchk(3'h7);
    rd(8'h90, 1'b0, 8'h0d);
    @(posedge i_sys_clk);
    {ext_val[15:8], i_first_port_compare_mask} <= 16'h0c02;
    mchk(3'h7);
    ext_val[1] <= 1'b0;
    mchk(3'h0);
    $display("match test done");
    results();
  end
endmodule // port_io_with_match_detect_tb
`default_nettype wire
